// ### src/ncab_bank.v
// Address, hash and boot flash register bank with APB slave
// Contract
// - Current transmit descriptor address is a 32-bit read-only register.
// - Current receive descriptor address is a 32-bit read-only register.
// - Raise transmit-complete after burst-count good transmits, repeating forever.
// - Timeout counter decrements in 2.56/25.6 us units while deferred enable set.
// - Timer expiry before next transmit start raises transmit-deferred interrupt.
// - A16 select drives shared pin as flash address bit 16 in four-LED mode.
// - Read enable self-clears once flash read byte is in data field.
// - Write enable self-clears once flash byte write completes.
// - Flash address in bits 25:8, data byte in bits 7:0.
// - Station address loads from EEPROM, no fixed reset value.
// - Station bytes 0-3 in low word, 4-5 in high word low half.
// - Station address always readable, writable only when receive stopped.
// - Hash registers reset zero, hold 64-entry table low then high.
// - Hash registers always readable, writable only when receive stopped.
// - CRC-32 of destination address, six low bits pick a hash entry.
// - CRC bit 5 picks high or low register, bits 4:0 the bit.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ncab_regs.vh"
module ncab_bank #(
    parameter UNIT_100_CYC = `NCAB_UNIT_100_CYC,
    parameter UNIT_10_CYC  = `NCAB_UNIT_10_CYC,
    parameter FLASH_CYC    = `NCAB_FLASH_CYC
) (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Engine state
    input  wire [31:0] tx_desc_ptr,
    input  wire [31:0] rx_desc_ptr,
    input  wire [2:0]  rx_state,
    input  wire        speed_100,
    input  wire        tx_good,
    input  wire        tx_start,
    input  wire        tx_deferred_irq_enable,
    input  wire        four_led_mode,
    input  wire        led_fdcol,
    // EEPROM load of station address
    input  wire        ee_load,
    input  wire [47:0] ee_station,
    // Receive filter
    input  wire        da_valid,
    input  wire [47:0] da_addr,
    output reg         hash_hit,
    // Boot flash port
    output reg  [17:0] flash_addr,
    output reg  [7:0]  flash_wdata,
    output reg         flash_data_oe,
    input  wire [7:0]  flash_rdata,
    output reg         flash_oe_n,
    output reg         flash_we_n,
    output reg         shared_pin,
    // Interrupt
    output reg         irq
);
    localparam ST_IDLE = 3'b001;
    localparam ST_RD   = 3'b010;
    localparam ST_WR   = 3'b100;

    reg [31:0] txdp_r, rxdp_r;
    reg [4:0]  burst_r;
    reg [11:0] tto_r, tmr_r;
    reg [15:0] unit_r;
    reg [4:0]  bcnt_r;
    reg        armed_r;
    reg        a16sel_r, ren_r, wen_r;
    reg [17:0] faddr_r;
    reg [7:0]  fdata_r;
    reg [2:0]  fst_r;
    reg [15:0] fcnt_r;
    reg [47:0] sta_r;
    reg [63:0] hash_r;
    reg [2:0]  ists_r, imsk_r;
    reg [2:0]  rxs_s1, rxs_s2;
    reg        gd_s1, gd_s2, st_s1, st_s2, en_s1, en_s2, sp_s1, sp_s2, fl_s1, fl_s2;
    reg [7:0]  rd_s1, rd_s2;
    reg [1:0]  tx_ev_r;
    reg        fl_ev_r;

    // Event strobes into status
    wire [2:0] ev = {fl_ev_r, tx_ev_r};

    wire acc    = psel & penable & pready;
    wire wr     = acc & pwrite;
    wire rx_off = (rxs_s2 == 3'b000);

    // Input synchronisers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxs_s1 <= 3'h0;
            rxs_s2 <= 3'h0;
            gd_s1  <= 1'b0;
            gd_s2  <= 1'b0;
            st_s1  <= 1'b0;
            st_s2  <= 1'b0;
            en_s1  <= 1'b0;
            en_s2  <= 1'b0;
            sp_s1  <= 1'b0;
            sp_s2  <= 1'b0;
            fl_s1  <= 1'b0;
            fl_s2  <= 1'b0;
            rd_s1  <= 8'h00;
            rd_s2  <= 8'h00;
        end else begin
            rxs_s1 <= rx_state;
            rxs_s2 <= rxs_s1;
            gd_s1  <= tx_good;
            gd_s2  <= gd_s1;
            st_s1  <= tx_start;
            st_s2  <= st_s1;
            en_s1  <= tx_deferred_irq_enable;
            en_s2  <= en_s1;
            sp_s1  <= speed_100;
            sp_s2  <= sp_s1;
            fl_s1  <= four_led_mode;
            fl_s2  <= fl_s1;
            rd_s1  <= flash_rdata;
            rd_s2  <= rd_s1;
        end
    end

    // Edge detect on synchronised pulses
    reg gd_d, st_d;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gd_d <= 1'b0;
            st_d <= 1'b0;
        end else begin
            gd_d <= gd_s2;
            st_d <= st_s2;
        end
    end
    wire good_ev  = gd_s2 & ~gd_d;
    wire start_ev = st_s2 & ~st_d;

    always @(posedge pclk) begin
        txdp_r <= tx_desc_ptr;
        rxdp_r <= rx_desc_ptr;
    end

    // Transmit moderation
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_r <= 5'h00;
            tto_r   <= 12'h000;
            bcnt_r  <= 5'h00;
            tmr_r   <= 12'h000;
            unit_r  <= 16'h0000;
            armed_r <= 1'b0;
            tx_ev_r <= 2'b00;
        end else begin
            tx_ev_r <= 2'b00;
            if (wr && paddr == `NCAB_OFF_TXBT) begin
                burst_r <= pwdata[20:16];
                tto_r   <= pwdata[11:0];
            end
            if (good_ev && burst_r != 5'h00) begin
                if (bcnt_r + 5'h01 >= burst_r) begin
                    bcnt_r <= 5'h00;
                    tx_ev_r[0] <= 1'b1;
                end else begin
                    bcnt_r <= bcnt_r + 5'h01;
                end
            end
            if (start_ev || !en_s2) begin
                tmr_r   <= tto_r;
                unit_r  <= 16'h0000;
                armed_r <= (tto_r != 12'h000);
            end else if (armed_r) begin
                if (unit_r >= (sp_s2 ? UNIT_100_CYC[15:0] : UNIT_10_CYC[15:0]) - 16'h0001) begin
                    unit_r <= 16'h0000;
                    if (tmr_r <= 12'h001) begin
                        tmr_r   <= 12'h000;
                        armed_r <= 1'b0;
                        tx_ev_r[1] <= 1'b1;
                    end else begin
                        tmr_r <= tmr_r - 12'h001;
                    end
                end else begin
                    unit_r <= unit_r + 16'h0001;
                end
            end
        end
    end

    // Flash port engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a16sel_r      <= 1'b1;
            ren_r         <= 1'b0;
            wen_r         <= 1'b0;
            faddr_r       <= 18'h00000;
            fdata_r       <= 8'h00;
            fst_r         <= ST_IDLE;
            fcnt_r        <= 16'h0000;
            fl_ev_r       <= 1'b0;
            flash_addr    <= 18'h00000;
            flash_wdata   <= 8'h00;
            flash_data_oe <= 1'b0;
            flash_oe_n    <= 1'b1;
            flash_we_n    <= 1'b1;
            shared_pin    <= 1'b0;
        end else begin
            fl_ev_r <= 1'b0;
            shared_pin <= (fl_s2 && a16sel_r) ? faddr_r[16] : led_fdcol;
            case (fst_r)
                ST_IDLE: begin
                    if (wr && paddr == `NCAB_OFF_FLASH) begin
                        a16sel_r <= pwdata[`NCAB_FL_A16SEL];
                        faddr_r  <= pwdata[25:8];
                        fdata_r  <= pwdata[7:0];
                        ren_r    <= pwdata[`NCAB_FL_REN];
                        wen_r    <= pwdata[`NCAB_FL_WEN] & ~pwdata[`NCAB_FL_REN];
                        fcnt_r   <= 16'h0000;
                        flash_addr <= pwdata[25:8];
                        flash_wdata <= pwdata[7:0];
                        if (pwdata[`NCAB_FL_REN]) begin
                            fst_r <= ST_RD;
                            flash_oe_n <= 1'b0;
                        end else if (pwdata[`NCAB_FL_WEN]) begin
                            fst_r <= ST_WR;
                            flash_we_n <= 1'b0;
                            flash_data_oe <= 1'b1;
                        end
                    end
                end
                ST_RD: begin
                    fcnt_r <= fcnt_r + 16'h0001;
                    if (fcnt_r >= FLASH_CYC[15:0]) begin
                        fdata_r <= rd_s2;
                        ren_r <= 1'b0;
                        flash_oe_n <= 1'b1;
                        fl_ev_r <= 1'b1;
                        fst_r <= ST_IDLE;
                    end
                end
                ST_WR: begin
                    fcnt_r <= fcnt_r + 16'h0001;
                    if (fcnt_r >= FLASH_CYC[15:0]) begin
                        wen_r <= 1'b0;
                        flash_we_n <= 1'b1;
                        flash_data_oe <= 1'b0;
                        fl_ev_r <= 1'b1;
                        fst_r <= ST_IDLE;
                    end
                end
                default: fst_r <= ST_IDLE;
            endcase
        end
    end

    // Station address, loaded from EEPROM, no reset
    always @(posedge pclk) begin
        if (ee_load) begin
            sta_r <= ee_station;
        end else if (wr && rx_off) begin
            if (paddr == `NCAB_OFF_STA_LO)
                sta_r[31:0] <= pwdata;
            // High word keeps bytes 4 and 5
            if (paddr == `NCAB_OFF_STA_HI)
                sta_r[47:32] <= pwdata[15:0];
        end
    end

    // CRC-32 over destination address, first octet first
    function [31:0] crc48;
        input [47:0] d;
        integer i;
        reg [31:0] c;
        begin
            c = 32'hFFFFFFFF;
            for (i = 0; i < 48; i = i + 1)
                c = (c[0] ^ d[i]) ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
            crc48 = c;
        end
    endfunction
    wire [31:0] crc = crc48(da_addr);

    // Hash table and lookup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hash_r   <= 64'h0000000000000000;
            hash_hit <= 1'b0;
        end else begin
            if (wr && rx_off && paddr == `NCAB_OFF_HASH_LO)
                hash_r[31:0] <= pwdata;
            if (wr && rx_off && paddr == `NCAB_OFF_HASH_HI)
                hash_r[63:32] <= pwdata;
            // Bit 5 picks word, 4:0 picks bit
            hash_hit <= da_valid & hash_r[{crc[5], crc[4:0]}];
        end
    end

    // Interrupt status and mask
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ists_r <= 3'h0;
            imsk_r <= 3'h0;
            irq    <= 1'b0;
        end else begin
            if (wr && paddr == `NCAB_OFF_IRQ_MSK)
                imsk_r <= pwdata[2:0];
            // Set wins over clear
            ists_r <= (ists_r & ~((wr && paddr == `NCAB_OFF_IRQ_STS) ? pwdata[2:0] : 3'h0)) | ev;
            irq    <= |(ists_r & imsk_r);
        end
    end

    // APB read mux
    reg [31:0] rd_mux;
    reg        hit;
    always @* begin
        rd_mux = 32'h00000000;
        hit    = 1'b1;
        case (paddr)
            `NCAB_OFF_TXDP:    rd_mux = txdp_r;
            `NCAB_OFF_RXDP:    rd_mux = rxdp_r;
            `NCAB_OFF_TXBT:    rd_mux = {11'h000, burst_r, 4'h0, tto_r};
            `NCAB_OFF_FLASH:   rd_mux = {a16sel_r, 3'h0, ren_r, wen_r, faddr_r, fdata_r};
            `NCAB_OFF_STA_LO:  rd_mux = sta_r[31:0];
            `NCAB_OFF_STA_HI:  rd_mux = {16'h0000, sta_r[47:32]};
            `NCAB_OFF_HASH_LO: rd_mux = hash_r[31:0];
            `NCAB_OFF_HASH_HI: rd_mux = hash_r[63:32];
            `NCAB_OFF_IRQ_STS: rd_mux = {29'h00000000, ists_r};
            `NCAB_OFF_IRQ_MSK: rd_mux = {29'h00000000, imsk_r};
            default:           hit = 1'b0;
        endcase
    end

    // APB slave, one wait state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end
endmodule // ncab_bank
`default_nettype wire

// ### src/ncab_regs.vh
// Register offsets, fields and timing constants of the address and flash bank
`ifndef NCAB_REGS_VH
`define NCAB_REGS_VH
`define NCAB_OFF_TXDP     8'h94
`define NCAB_OFF_RXDP     8'h98
`define NCAB_OFF_TXBT     8'h9C
`define NCAB_OFF_FLASH    8'hA0
`define NCAB_OFF_STA_LO   8'hA4
`define NCAB_OFF_STA_HI   8'hA8
`define NCAB_OFF_HASH_LO  8'hAC
`define NCAB_OFF_HASH_HI  8'hB0
`define NCAB_OFF_IRQ_STS  8'hC0
`define NCAB_OFF_IRQ_MSK  8'hC4
`define NCAB_FL_A16SEL    31
`define NCAB_FL_REN       27
`define NCAB_FL_WEN       26
`define NCAB_FLASH_RST    32'h80000000
`define NCAB_UNIT_100_NS  2560
`define NCAB_UNIT_10_NS   25600
`define NCAB_CLK_NS       5
`define NCAB_UNIT_100_CYC (`NCAB_UNIT_100_NS / `NCAB_CLK_NS)
`define NCAB_UNIT_10_CYC  (`NCAB_UNIT_10_NS / `NCAB_CLK_NS)
`define NCAB_FLASH_NS     100
`define NCAB_FLASH_CYC    (`NCAB_FLASH_NS / `NCAB_CLK_NS)
`define NCAB_IRQ_TXDONE   0
`define NCAB_IRQ_TXDEF    1
`define NCAB_IRQ_FLASH    2
`endif

// ### verification/ncab_bank_sva.sv
// Port checks for the address, hash and flash bank
`timescale 1ns/1ps
`default_nettype none
`include "ncab_regs.vh"
module ncab_bank_sva (
    // Clock, reset and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    // Engine state and pins
    input wire logic [31:0] tx_desc_ptr,
    input wire logic [31:0] rx_desc_ptr,
    input wire logic        four_led_mode,
    input wire logic        led_fdcol,
    input wire logic        shared_pin,
    input wire logic        flash_oe_n,
    input wire logic        flash_we_n,
    input wire logic        flash_data_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_ok = psel && penable && !pwrite && pready;
    a_txptr_read: assert property (rd_ok && paddr == `NCAB_OFF_TXDP
        && $past(tx_desc_ptr, 3) == tx_desc_ptr |-> prdata == tx_desc_ptr)
        else $error("tx pointer read wrong");
    a_rxptr_read: assert property (rd_ok && paddr == `NCAB_OFF_RXDP
        && $past(rx_desc_ptr, 3) == rx_desc_ptr |-> prdata == rx_desc_ptr)
        else $error("rx pointer read wrong");
    a_burst_rsv: assert property (rd_ok && paddr == `NCAB_OFF_TXBT
        |-> prdata[31:21] == 11'h0 && prdata[15:12] == 4'h0) else $error("burst reserved set");
    a_flash_rsv: assert property (rd_ok && paddr == `NCAB_OFF_FLASH
        |-> prdata[30:28] == 3'h0) else $error("flash reserved set");
    a_sta_hi_rsv: assert property (rd_ok && paddr == `NCAB_OFF_STA_HI
        |-> prdata[31:16] == 16'h0) else $error("station high reserved set");
    a_led_pin_mux: assert property ((!four_led_mode && $stable(led_fdcol))[*4]
        |-> shared_pin == led_fdcol) else $error("shared pin not led");
    a_read_ends: assert property ($fell(flash_oe_n) |-> ##[1:40] flash_oe_n)
        else $error("flash read strobe stuck");
    a_write_ends: assert property ($fell(flash_we_n) |-> ##[1:40] flash_we_n)
        else $error("flash write strobe stuck");
    a_write_drive: assert property (!flash_we_n |-> flash_data_oe)
        else $error("write data not driven");
    cover property (rd_ok && paddr == `NCAB_OFF_FLASH);
    cover property ($fell(flash_we_n));
    cover property ($fell(flash_oe_n));
endmodule // ncab_bank_sva
bind ncab_bank ncab_bank_sva i_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .tx_desc_ptr, .rx_desc_ptr, .four_led_mode, .led_fdcol, .shared_pin,
    .flash_oe_n, .flash_we_n, .flash_data_oe);
`default_nettype wire

// ### verification/nic_csr_address_flash_bank_tb_top.sv
// Self-checking bench for the address, hash and flash bank
`timescale 1ns/1ps
`default_nettype none
`include "ncab_regs.vh"
module nic_csr_address_flash_bank_tb_top;
    logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, pready, pslverr;
    logic [7:0]  paddr = '0, flash_rdata = '0, flash_wdata, fd;
    logic [31:0] pwdata = '0, prdata, rv, tx_desc_ptr = '0, rx_desc_ptr = '0;
    logic [2:0]  rx_state = '0;
    logic        speed_100 = '1, tx_good = '0, tx_start = '0, tx_deferred_irq_enable = '0;
    logic        four_led_mode = '0, led_fdcol = '1, ee_load = '0, da_valid = '0, dv_d = '0;
    logic        hash_hit, flash_data_oe, flash_oe_n, flash_we_n, shared_pin, irq;
    logic [47:0] ee_station = '0, da_addr = '0;
    logic [17:0] flash_addr, fa;
    logic [63:0] r64, h64;
    logic [32:0] eq[$];
    logic [31:0] mq[$];
    logic        hq[$];
    int          n_errors = 0, cmp_count = 0, n;
    ncab_bank #(.UNIT_100_CYC(4), .UNIT_10_CYC(16), .FLASH_CYC(4)) i_dut (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_desc_ptr,
        .rx_desc_ptr, .rx_state, .speed_100, .tx_good, .tx_start, .tx_deferred_irq_enable,
        .four_led_mode, .led_fdcol, .ee_load, .ee_station, .da_valid, .da_addr, .hash_hit,
        .flash_addr, .flash_wdata, .flash_data_oe, .flash_rdata, .flash_oe_n, .flash_we_n,
        .shared_pin, .irq);
    always #2.5 pclk = ~pclk;
    task results();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
             input logic [31:0] m);
        int k;
        k = 0;
        @(posedge pclk);
        if (!w) begin
            eq.push_back(e & {1'h1, m});
            mq.push_back(m);
        end
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 50);
        if (pready !== 1'h1) begin
            n_errors++;
            results();
        end
        rv = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d, '0, '0);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic se);
        apb(1'h0, a, '0, {se, e}, m);
    endtask
    task flash(input logic [31:0] cmd, input int b);
        int k;
        k = 0;
        wr(`NCAB_OFF_FLASH, cmd);
        do begin
            rd(`NCAB_OFF_FLASH, '0, '0, 1'h0);
            k++;
        end while (rv[b] !== 1'h0 && k < 20);
    endtask
    function automatic logic [5:0] crc6(input logic [47:0] d);
        logic [31:0] c;
        c = '1;
        for (int i = 0; i < 48; i++)
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? 32'hEDB88320 : 32'h0);
        return c[5:0];
    endfunction
    // Result watcher
    always @(posedge pclk) begin
        dv_d <= da_valid;
        if (psel && penable && pready && !pwrite)
            chk("prdata", eq.pop_front(), {pslverr, prdata} & {1'h1, mq.pop_front()});
        if (dv_d)
            chk("hash_hit", {32'h0, hq.pop_front()}, {32'h0, hash_hit});
        if (!flash_we_n || !flash_oe_n)
            chk("flash_addr", fa, flash_addr);
        if (!flash_we_n)
            chk("flash_wdata", fd, flash_wdata);
    end
    initial begin
        #100us;
        n_errors++;
        results();
    end
    initial begin
        void'($urandom(32'hD5820999));
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        rd(`NCAB_OFF_FLASH, `NCAB_FLASH_RST, '1, 1'h0);
        rd(`NCAB_OFF_TXBT, '0, '1, 1'h0);
        rd(`NCAB_OFF_HASH_LO, '0, '1, 1'h0);
        rd(`NCAB_OFF_HASH_HI, '0, '1, 1'h0);
        rd(8'hB8, '0, '1, 1'h1);
        tx_desc_ptr <= $urandom;
        rx_desc_ptr <= $urandom;
        wr(`NCAB_OFF_TXDP, '1);
        rd(`NCAB_OFF_TXDP, tx_desc_ptr, '1, 1'h0);
        rd(`NCAB_OFF_RXDP, rx_desc_ptr, '1, 1'h0);
        $display("Test reset and pointers done");
        r64 = {$urandom, $urandom};
        ee_station <= r64[47:0];
        ee_load <= 1'h1;
        @(posedge pclk);
        ee_load <= 1'h0;
        rd(`NCAB_OFF_STA_LO, r64[31:0], '1, 1'h0);
        rd(`NCAB_OFF_STA_HI, {16'h0, r64[47:32]}, '1, 1'h0);
        rx_state <= 3'h2;
        repeat (3) @(posedge pclk);
        wr(`NCAB_OFF_STA_LO, ~r64[31:0]);
        wr(`NCAB_OFF_HASH_HI, '1);
        rd(`NCAB_OFF_STA_LO, r64[31:0], '1, 1'h0);
        rd(`NCAB_OFF_HASH_HI, '0, '1, 1'h0);
        rx_state <= 3'h0;
        repeat (3) @(posedge pclk);
        wr(`NCAB_OFF_STA_HI, '1);
        rd(`NCAB_OFF_STA_HI, 32'h0000FFFF, '1, 1'h0);
        h64 = {$urandom, $urandom};
        wr(`NCAB_OFF_HASH_LO, h64[31:0]);
        wr(`NCAB_OFF_HASH_HI, h64[63:32]);
        rd(`NCAB_OFF_HASH_LO, h64[31:0], '1, 1'h0);
        repeat (24) begin
            r64 = {$urandom, $urandom};
            hq.push_back(h64[crc6(r64[47:0])]);
            da_addr <= r64[47:0];
            da_valid <= 1'h1;
            @(posedge pclk);
            da_valid <= 1'h0;
            @(posedge pclk);
        end
        $display("Test station and hash done");
        fa = 18'($urandom) | 18'h10000;
        fd = 8'($urandom);
        led_fdcol <= 1'h0;
        flash({6'h21, fa, fd}, `NCAB_FL_WEN);
        rd(`NCAB_OFF_FLASH, {6'h20, fa, fd}, '1, 1'h0);
        flash_rdata <= 8'($urandom);
        flash({6'h22, fa, 8'h00}, `NCAB_FL_REN);
        rd(`NCAB_OFF_FLASH, {6'h20, fa, flash_rdata}, '1, 1'h0);
        four_led_mode <= 1'h1;
        repeat (4) @(posedge pclk);
        chk("shared_pin", fa[16], shared_pin);
        wr(`NCAB_OFF_FLASH, {6'h00, fa, fd});
        repeat (2) @(posedge pclk);
        chk("shared_pin", 1'h0, shared_pin);
        four_led_mode <= 1'h0;
        led_fdcol <= 1'h1;
        rd(`NCAB_OFF_IRQ_STS, 32'h4, 32'h4, 1'h0);
        chk("irq", 1'h0, irq);
        wr(`NCAB_OFF_IRQ_MSK, 32'h4);
        repeat (2) @(posedge pclk);
        chk("irq", 1'h1, irq);
        wr(`NCAB_OFF_IRQ_STS, 32'h4);
        repeat (2) @(posedge pclk);
        chk("irq", 1'h0, irq);
        wr(`NCAB_OFF_IRQ_MSK, 32'h7);
        $display("Test flash and interrupt done");
        wr(`NCAB_OFF_TXBT, 32'h00030000);
        for (n = 1; n <= 6; n++) begin
            tx_good <= 1'h1;
            @(posedge pclk);
            tx_good <= 1'h0;
            repeat (5) @(posedge pclk);
            rd(`NCAB_OFF_IRQ_STS, {31'h0, n % 3 == 0}, 32'h1, 1'h0);
            wr(`NCAB_OFF_IRQ_STS, 32'h1);
        end
        wr(`NCAB_OFF_TXBT, 32'h00000003);
        tx_deferred_irq_enable <= 1'h1;
        repeat (4) @(posedge pclk);
        rd(`NCAB_OFF_IRQ_STS, 32'h0, 32'h2, 1'h0);
        repeat (20) @(posedge pclk);
        rd(`NCAB_OFF_IRQ_STS, 32'h2, 32'h2, 1'h0);
        chk("irq", 1'h1, irq);
        wr(`NCAB_OFF_IRQ_STS, 32'h2);
        tx_deferred_irq_enable <= 1'h0;
        speed_100 <= 1'h0;
        repeat (4) @(posedge pclk);
        tx_deferred_irq_enable <= 1'h1;
        repeat (20) @(posedge pclk);
        rd(`NCAB_OFF_IRQ_STS, 32'h0, 32'h2, 1'h0);
        repeat (50) @(posedge pclk);
        rd(`NCAB_OFF_IRQ_STS, 32'h2, 32'h2, 1'h0);
        wr(`NCAB_OFF_IRQ_STS, 32'h2);
        speed_100 <= 1'h1;
        repeat (6) begin
            tx_start <= 1'h1;
            @(posedge pclk);
            tx_start <= 1'h0;
            repeat (7) @(posedge pclk);
        end
        rd(`NCAB_OFF_IRQ_STS, 32'h0, 32'h2, 1'h0);
        repeat (20) @(posedge pclk);
        rd(`NCAB_OFF_IRQ_STS, 32'h2, 32'h2, 1'h0);
        $display("Test burst and timeout done");
        results();
    end
endmodule // nic_csr_address_flash_bank_tb_top
`default_nettype wire
